// ### common/port_level_pkg.sv
// shared constants and carrier types for the port intensity bank
package port_level_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] LEVEL_1_0_ADDR = 8'h10;
    localparam logic [7:0] LEVEL_3_2_ADDR = 8'h11;
    localparam logic [7:0] LEVEL_5_4_ADDR = 8'h12;
    localparam logic [7:0] LEVEL_7_6_ADDR = 8'h13;
    localparam logic [7:0] LEVEL_RESET    = 8'hFF;
    localparam logic [3:0] CODE_STATIC    = 4'hF;
    localparam logic [3:0] GLOBAL_OFF     = 4'h0;
    localparam logic [3:0] PHASE_LAST     = 4'hF;
    localparam logic [3:0] PHASE_START    = 4'h0;
    localparam int         CODE_W         = 4;

    // ------------------------------------------------------------
    // register access carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic       valid;
        logic       hit;
        logic [7:0] rdata;
    } reg_rsp_t;
endpackage : port_level_pkg

// ### design/port_output_intensity_bank.sv
// per-port pwm intensity bank for port lines zero to seven
//
// Operation
// - address 10h holds line one code in high nibble, line zero in low
// - codes 0 to 14 give duty of code plus one sixteenths
// - code 15 holds the output static, no modulation
// - address 11h: high nibble line three, low nibble line two
// - address 12h: high nibble line five, low nibble line four
// - address 13h: high nibble line seven, low nibble line six
// - registers are written and read back in identical bit positions
// - only unused expander addresses used; power-up matches legacy behaviour
// - global level zero stops oscillator; all outputs static
// - intensity span 10h-13h; power-up leaves intensity features disabled
`timescale 1ns/1ps
module port_output_intensity_bank
    import port_level_pkg::*;
#(
    parameter int PORTS = 8
) (
    input  wire logic                    sys_clk_i,
    input  wire logic                    rst_i,
    input  wire logic                    clk_en_i,
    input  wire port_level_pkg::reg_req_t req_i,
    input  wire logic [3:0]              global_level_code_i,
    input  wire logic [PORTS-1:0]        static_level_i,
    output port_level_pkg::reg_rsp_t     rsp_o,
    output logic [PORTS-1:0]             port_line_o,
    output logic [PORTS-1:0]             port_line_oe_o,
    output logic [3:0]                   pwm_phase_o
);
    import port_level_pkg::*;

    // ------------------------------------------------------------
    // intensity registers
    // ------------------------------------------------------------
    logic [7:0]       level_q [PORTS/2];
    logic [3:0]       code    [PORTS];
    logic [CODE_W*PORTS-1:0] code_flat;
    logic [PORTS-1:0] drain_q;
    logic [3:0]       phase_q;
    logic             osc_run;
    logic [PORTS-1:0] drive_d;
    logic [PORTS-1:0] line_q;
    logic             sel_hit;
    logic [1:0]       sel_idx;
    reg_rsp_t         rsp_q;

    assign osc_run = (global_level_code_i != GLOBAL_OFF);
    // decode 10h-13h; 14h-17h belong to the upper ports, not this bank
    assign sel_hit = (req_i.addr[7:2] == LEVEL_1_0_ADDR[7:2]);
    assign sel_idx = req_i.addr[1:0];

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < PORTS/2; i++) begin
                level_q[i] <= LEVEL_RESET;
            end
        end else if (clk_en_i && req_i.wr && sel_hit) begin
            level_q[sel_idx] <= req_i.wdata;
        end
    end

    generate
        for (genvar p = 0; p < PORTS; p++) begin : g_code
            // odd line in high nibble, even line in low nibble
            assign code[p] = level_q[p/2][(p%2)*CODE_W +: CODE_W];
            // packed copy so the checks can compare all codes at once
            assign code_flat[p*CODE_W +: CODE_W] = code[p];
        end
    endgenerate

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rsp_q <= '0;
        end else if (clk_en_i) begin
            rsp_q.valid <= req_i.rd;
            rsp_q.hit   <= req_i.rd && sel_hit;
            // same positions as written
            rsp_q.rdata <= (req_i.rd && sel_hit) ? level_q[sel_idx] : 8'h00;
        end
    end
    assign rsp_o = rsp_q;

    // ------------------------------------------------------------
    // shared pwm timebase
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            phase_q <= PHASE_START;
        end else if (clk_en_i) begin
            if (!osc_run) begin
                phase_q <= PHASE_START;
            end else begin
                phase_q <= phase_q + 4'h1;
            end
        end
    end

    always_comb begin
        for (int p = 0; p < PORTS; p++) begin
            if (!osc_run || code[p] == CODE_STATIC) begin
                drive_d[p] = static_level_i[p];
            end else begin
                // active while phase <= code: code+1 slots of sixteen
                drive_d[p] = (phase_q <= code[p]);
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            line_q <= '0;
        end else if (clk_en_i) begin
            line_q <= drive_d;
        end
    end

    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    // open drain: pin pulled low while active, released otherwise;
    // value bit kept in a flop so every output leaves a register
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            drain_q <= '0;
        end else if (clk_en_i) begin
            drain_q <= '0;
        end
    end

    assign port_line_o    = drain_q;
    assign port_line_oe_o = line_q;
    assign pwm_phase_o    = phase_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    duty_count_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (clk_en_i && osc_run && code[0] != CODE_STATIC && !(req_i.wr && sel_hit))
        |=> (line_q[0] == ($past(phase_q) <= $past(code[0]))))
        else $error("line zero duty mismatch");
    static_code_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (clk_en_i && code[1] == CODE_STATIC) |=> line_q[1] == $past(static_level_i[1]))
        else $error("static code still modulated");
    osc_stop_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (clk_en_i && !osc_run) |=> (phase_q == 4'h0 && line_q == $past(static_level_i)))
        else $error("oscillator not stopped");
    phase_step_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (clk_en_i && osc_run) |=> phase_q == $past(phase_q) + 4'h1)
        else $error("shared period not advancing");
    readback_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (clk_en_i && req_i.wr && sel_hit) ##1 (clk_en_i && req_i.rd && !req_i.wr
        && req_i.addr == $past(req_i.addr)) |=> rsp_o.rdata == $past(req_i.wdata, 2))
        else $error("read back differs from write");
    map_pair_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (clk_en_i && req_i.wr && req_i.addr == LEVEL_1_0_ADDR)
        |=> (code[1] == $past(req_i.wdata[7:4]) && code[0] == $past(req_i.wdata[3:0])))
        else $error("pair one zero mapping wrong");
    map_seven_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (clk_en_i && req_i.wr && req_i.addr == LEVEL_7_6_ADDR)
        |=> (code[7] == $past(req_i.wdata[7:4]) && code[6] == $past(req_i.wdata[3:0])))
        else $error("pair seven six mapping wrong");
    map_five_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (clk_en_i && req_i.wr && req_i.addr == LEVEL_5_4_ADDR)
        |=> (code[5] == $past(req_i.wdata[7:4]) && code[4] == $past(req_i.wdata[3:0])))
        else $error("pair five four mapping wrong");
    map_three_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (clk_en_i && req_i.wr && req_i.addr == LEVEL_3_2_ADDR)
        |=> (code[3] == $past(req_i.wdata[7:4]) && code[2] == $past(req_i.wdata[3:0])))
        else $error("pair three two mapping wrong");
    outside_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (clk_en_i && req_i.rd && !sel_hit)
        |=> (rsp_o.valid && rsp_o.hit == 1'b0 && rsp_o.rdata == 8'h00))
        else $error("foreign address answered");
    write_ignore_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (clk_en_i && req_i.wr && !sel_hit) |=> code_flat == $past(code_flat))
        else $error("foreign write landed");
    read_pair_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (clk_en_i && req_i.rd && req_i.addr == LEVEL_1_0_ADDR)
        |=> (rsp_o.hit && rsp_o.rdata == $past(code_flat[7:0])))
        else $error("pair one zero read wrong");
    read_pulse_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        clk_en_i |=> rsp_o.valid == $past(req_i.rd))
        else $error("read answer not one cycle");
    phase_wrap_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (clk_en_i && osc_run && phase_q == PHASE_LAST) |=> phase_q == PHASE_START)
        else $error("period is not sixteen steps");
    equal_codes_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        (clk_en_i && code[3] == code[7] && static_level_i[3] == static_level_i[7])
        |=> line_q[3] == line_q[7])
        else $error("equal codes not together");

    // ------------------------------------------------------------
    // reset and enable checks
    // ------------------------------------------------------------
    // sampled on the first edge after release, before any write can land
    reset_state_a: assert property (@(posedge sys_clk_i)
        $fell(rst_i) |-> (code_flat == {PORTS{CODE_STATIC}} && phase_q == PHASE_START
        && line_q == '0 && rsp_q == '0 && drain_q == '0))
        else $error("power-up state not disabled");
    freeze_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !clk_en_i |=> (phase_q == $past(phase_q) && line_q == $past(line_q)
        && code_flat == $past(code_flat) && rsp_q == $past(rsp_q) && drain_q == $past(drain_q)))
        else $error("state moved while disabled");

    // ------------------------------------------------------------
    // per-line checks
    // ------------------------------------------------------------
    // every line, not only the first two, follows the shared period
    generate
        for (genvar p = 0; p < PORTS; p++) begin : g_line_chk
            duty_line_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
                (clk_en_i && osc_run && code[p] != CODE_STATIC)
                |=> line_q[p] == ($past(phase_q) <= $past(code[p])))
                else $error("line duty mismatch");
            static_line_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
                (clk_en_i && code[p] == CODE_STATIC) |=> line_q[p] == $past(static_level_i[p]))
                else $error("static line modulated");
        end
    endgenerate
endmodule : port_output_intensity_bank

// ### verif/level_host_model.sv
// register bus controller model for the intensity bank
`timescale 1ns/1ps
module level_host_model
    import port_level_pkg::*;
(
    input  wire logic                     sys_clk_i,
    input  wire port_level_pkg::reg_rsp_t rsp_i,
    output port_level_pkg::reg_req_t      req_o
);
    initial req_o = '0;
    // one access per call; idle address and data show the inverse, never a stale copy
    task automatic access(input logic wr, input logic [7:0] ad, input logic [7:0] wd,
                          output port_level_pkg::reg_rsp_t rsp);
        @(posedge sys_clk_i);
        req_o <= '{wr: wr, rd: !wr, addr: ad, wdata: wd};
        @(posedge sys_clk_i);
        req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~ad, wdata: ~wd};
        #1 rsp = rsp_i;
    endtask : access

    // write then read of one address on consecutive edges, no idle cycle between
    task automatic write_read(input logic [7:0] ad, input logic [7:0] wd,
                              output port_level_pkg::reg_rsp_t rsp);
        @(posedge sys_clk_i);
        req_o <= '{wr: 1'b1, rd: 1'b0, addr: ad, wdata: wd};
        @(posedge sys_clk_i);
        req_o <= '{wr: 1'b0, rd: 1'b1, addr: ad, wdata: ~wd};
        @(posedge sys_clk_i);
        req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~ad, wdata: ~wd};
        #1 rsp = rsp_i;
    endtask : write_read
endmodule : level_host_model

// ### verif/port_output_intensity_bank_tb_top.sv
// self-checking bench for the port intensity bank
`timescale 1ns/1ps
module port_output_intensity_bank_tb_top;
    import port_level_pkg::*;
    logic       sys_clk_i = 1'b0;
    logic       rst_i     = 1'b1;
    logic [3:0] glob      = 4'h0;
    logic [7:0] stat      = 8'h00;
    logic       en        = 1'b1;
    logic [7:0] drain;
    logic [7:0] oe;
    logic [3:0] phase;
    reg_req_t   req;
    reg_rsp_t   rsp;
    reg_rsp_t   got;
    int         n_errors  = 0;
    int         checked   = 0;
    int         cycles    = 0;
    int         ones [8];
    logic [3:0] codes [8] = '{4'h0, 4'h1, 4'h7, 4'hE, 4'hF, 4'hF, 4'h3, 4'hE};

    port_output_intensity_bank port_output_intensity_bank_inst (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .clk_en_i(en), .req_i(req),
        .global_level_code_i(glob), .static_level_i(stat), .rsp_o(rsp),
        .port_line_o(drain), .port_line_oe_o(oe), .pwm_phase_o(phase));
    level_host_model level_host_model_inst (.sys_clk_i(sys_clk_i), .rsp_i(rsp), .req_o(req));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask : check

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict

    initial forever #2.5 sys_clk_i = ~sys_clk_i;
    // whole run needs about 110 cycles
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 4000) begin
            n_errors++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        logic [7:0]  ad;
        logic [11:0] held;
        logic [15:0] want;
        repeat (8) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        for (int a = 0; a < 4; a++) begin
            level_host_model_inst.access(1'b0, 8'h10 + 8'(a), 8'h00, got);
            check({got.valid, got.hit, got.rdata}, {2'b11, LEVEL_RESET}, "reset");
        end
        check(oe, 8'h00, "reset drive");
        check(drain, 8'h00, "drain value");
        $display("test reset done");
        for (int a = 0; a < 4; a++)
            level_host_model_inst.access(1'b1, 8'h10 + 8'(a), {codes[2*a+1], codes[2*a]}, got);
        for (int a = 0; a < 4; a++) begin
            level_host_model_inst.access(1'b0, 8'h10 + 8'(a), 8'h00, got);
            check(got.rdata, {codes[2*a+1], codes[2*a]}, "map");
        end
        level_host_model_inst.write_read(LEVEL_7_6_ADDR, {codes[7], codes[6]}, got);
        check({got.valid, got.hit, got.rdata}, {2'b11, codes[7], codes[6]}, "back to back");
        for (int a = 0; a < 2; a++) begin
            ad = a ? 8'h14 : 8'h0F;
            level_host_model_inst.access(1'b1, ad, 8'hAA, got);
            level_host_model_inst.access(1'b0, ad, 8'h00, got);
            check({got.valid, got.hit, got.rdata}, {2'b10, 8'h00}, "unmapped");
        end
        level_host_model_inst.access(1'b0, 8'h10, 8'h00, got);
        check(got.rdata, {codes[1], codes[0]}, "unmapped write leak");
        $display("test map done");
        @(posedge sys_clk_i);
        glob <= 4'h9;
        stat <= 8'h10;
        repeat (20) @(posedge sys_clk_i);
        ones = '{default: 0};
        repeat (16) begin
            @(posedge sys_clk_i);
            #1;
            for (int p = 0; p < 8; p++) ones[p] += oe[p];
            check(oe[3], oe[7], "equal codes apart");
        end
        for (int p = 0; p < 8; p++) begin
            want = (codes[p] == CODE_STATIC) ? (stat[p] ? 16'h0010 : 16'h0000)
                                             : 16'(codes[p]) + 16'h0001;
            check(16'(ones[p]), want, "duty");
        end
        $display("test duty done");
        @(posedge sys_clk_i);
        en <= 1'b0;
        @(posedge sys_clk_i);
        #1 held = {phase, oe};
        level_host_model_inst.access(1'b1, LEVEL_1_0_ADDR, 8'h77, got);
        level_host_model_inst.access(1'b0, LEVEL_1_0_ADDR, 8'h00, got);
        check(got.valid, 1'b0, "read while frozen");
        check({phase, oe}, held, "frozen state");
        @(posedge sys_clk_i);
        en <= 1'b1;
        level_host_model_inst.access(1'b0, LEVEL_1_0_ADDR, 8'h00, got);
        check(got.rdata, {codes[1], codes[0]}, "write while frozen");
        $display("test freeze done");
        @(posedge sys_clk_i);
        glob <= GLOBAL_OFF;
        stat <= 8'h5A;
        repeat (3) @(posedge sys_clk_i);
        repeat (16) begin
            @(posedge sys_clk_i);
            #1 check({phase, oe}, {4'h0, 8'h5A}, "global off");
        end
        $display("test global off done");
        give_verdict();
    end
endmodule : port_output_intensity_bank_tb_top
